/* ioxe_pkg.sv */
// constants, types and register map for the I/O output execution block
// ****************************************************************
// Functional notes
// RULE1 - step: fetch, write port, count down, advance
// RULE2 - end when count reaches zero, else repeat
// RULE3 - zero count at start gives 256 transfers
// RULE4 - interrupt may be taken between steps
// RULE5 - save instruction start pc before interrupt
// RULE6 - block end sets Z and N only
// RULE7 - user mode with inhibit bit traps
// RULE8 - single output writes one source byte
// RULE9 - address is page, count, port
// RULE10 - single output leaves flags alone
// RULE11 - register form final byte 01 r 001
// RULE12 - direct address 01 111 001 plus address
// RULE13 - indexed: xx 001 plus displacement
// RULE14 - relative: 01 000 001 plus displacement
// RULE15 - stack relative: 00 000 001 plus displacement
// RULE16 - base index field selects register pairs
// RULE17 - word step: low memory byte low half
// RULE18 - peripheral takes full 24-bit address
// ****************************************************************
package ioxe_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [10:0] REG_CTRL = 11'h000;
   localparam logic [10:0] REG_STATUS = 11'h004;
   localparam logic [10:0] REG_OPC_LO = 11'h008;
   localparam logic [10:0] REG_OPC_HI = 11'h00C;
   localparam logic [10:0] REG_BC = 11'h010;
   localparam logic [10:0] REG_HL = 11'h014;
   localparam logic [10:0] REG_IX = 11'h018;
   localparam logic [10:0] REG_IY = 11'h01C;
   localparam logic [10:0] REG_SP = 11'h020;
   localparam logic [10:0] REG_PC = 11'h024;
   localparam logic [10:0] REG_IOPAGE = 11'h028;
   localparam logic [10:0] REG_FLAGS = 11'h02C;
   localparam logic [10:0] REG_SAVED_PC = 11'h030;
   localparam logic [10:0] REG_DE = 11'h034;
   localparam logic [10:0] REG_ACC = 11'h038;
   localparam int MEM_SEL_BIT = 10;
   // ************************************************************
   // field positions and reset values
   // ************************************************************
   localparam int CTRL_START = 0;
   localparam int CTRL_USER = 1;
   localparam int CTRL_INHIBIT = 2;
   localparam int FLAG_Z = 6;
   localparam int FLAG_N = 1;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_RDATA = 32'h00000000;
   // ************************************************************
   // opcode bytes
   // ************************************************************
   localparam logic [7:0] OP_PFX_IX = 8'hDD;
   localparam logic [7:0] OP_PFX_IY = 8'hFD;
   localparam logic [7:0] OP_PFX_ED = 8'hED;
   localparam logic [7:0] OP_BLK_BYTE = 8'hB3;
   localparam logic [7:0] OP_BLK_WORD = 8'h93;
   localparam logic [2:0] OP_OUT_TAIL = 3'b001;
   localparam logic [1:0] OP_REG_HEAD = 2'b01;
   localparam logic [7:0] OP_DIRECT = 8'h79;
   localparam logic [7:0] OP_REL = 8'h41;
   localparam logic [7:0] OP_STACK = 8'h01;
   localparam logic [7:0] OP_X_IX = 8'h39;
   localparam logic [7:0] OP_X_IY = 8'h29;
   localparam logic [2:0] BX_HL_IX = 3'b001;
   localparam logic [2:0] BX_HL_IY = 3'b010;
   localparam logic [2:0] BX_IX_IY = 3'b011;
   localparam logic [15:0] REL_INSN_LEN = 16'h0005;
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_DECODE = 3'b001,
      ST_FETCH = 3'b010,
      ST_OUTPUT = 3'b011,
      ST_CHECK = 3'b100
   } ioxe_state_type;
   typedef struct packed
   {
      logic wr;
      logic word;
      logic [23:0] addr;
      logic [15:0] data;
   } ioxe_io_type;
endpackage

/* ioxe_exec.sv */
// I/O output instruction executor with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
module ioxe_exec
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [10:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic int_pending,
   output logic int_accept,
   output logic priv_trap,
   output ioxe_pkg::ioxe_io_type io_out
);
   import ioxe_pkg::*;

   logic wait_q;
   logic [31:0] rdata_q;
   logic wr_take;
   ioxe_state_type state_q;
   logic [15:0] bc_q, hl_q, ix_q, iy_q, sp_q, pc_q, de_q, saved_pc_q;
   logic [7:0] acc_q, page_q, flags_q;
   logic [31:0] opc_lo_q;
   logic [15:0] opc_hi_q;
   logic user_q, inhibit_q;
   logic done_q, trap_q, intr_q, illegal_q;
   logic is_block_q;
   logic word_q;
   logic [15:0] data_q;
   logic trap_pulse_q, accept_q;
   ioxe_io_type io_q;
   logic [7:0] mem [0:255];
   logic [7:0] ob [0:5];
   logic [7:0] fin, lo, hi, pfx;
   logic has_pfx;
   logic [15:0] disp, ea;
   logic dec_block, dec_word, dec_single, dec_mem, dec_bad;
   logic [7:0] src_reg;
   logic start_req;

   // ************************************************************
   // avalon slave: one wait cycle, then answer
   // ************************************************************
   assign wr_take = avs_write & ~wait_q;
   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0])
      begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         wait_q <= 1'b1;
      end
      else if ((avs_read | avs_write) & wait_q)
      begin
         wait_q <= 1'b0;
      end
      else
      begin
         wait_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         rdata_q <= RST_RDATA;
      end
      else if (avs_read & wait_q)
      begin
         rdata_q <= RST_RDATA;
         if (avs_address[MEM_SEL_BIT])
         begin
            rdata_q[7:0] <= mem[avs_address[9:2]];
         end
         else
         begin
            case (avs_address)
               REG_CTRL: rdata_q[2:0] <= {inhibit_q, user_q, 1'b0};
               REG_STATUS: rdata_q[7:0] <= {2'b00, is_block_q, illegal_q,
                                            intr_q, trap_q, done_q,
                                            state_q != ST_IDLE};
               REG_OPC_LO: rdata_q <= opc_lo_q;
               REG_OPC_HI: rdata_q[15:0] <= opc_hi_q;
               REG_BC: rdata_q[15:0] <= bc_q;
               REG_HL: rdata_q[15:0] <= hl_q;
               REG_IX: rdata_q[15:0] <= ix_q;
               REG_IY: rdata_q[15:0] <= iy_q;
               REG_SP: rdata_q[15:0] <= sp_q;
               REG_PC: rdata_q[15:0] <= pc_q;
               REG_IOPAGE: rdata_q[7:0] <= page_q;
               REG_FLAGS: rdata_q[7:0] <= flags_q;
               REG_SAVED_PC: rdata_q[15:0] <= saved_pc_q;
               REG_DE: rdata_q[15:0] <= de_q;
               REG_ACC: rdata_q[7:0] <= acc_q;
               default: rdata_q <= RST_RDATA;
            endcase
         end
      end
   end

   // ************************************************************
   // data memory, software loaded
   // ************************************************************
   // only 256 bytes: pointers wrap on their low byte
   always_ff @(posedge core_clk)
   begin
      if (wr_take & avs_address[MEM_SEL_BIT] & avs_byteenable[0])
      begin
         mem[avs_address[9:2]] <= avs_writedata[7:0];
      end
   end

   // ************************************************************
   // opcode decode
   // ************************************************************
   assign ob[0] = opc_lo_q[7:0];
   assign ob[1] = opc_lo_q[15:8];
   assign ob[2] = opc_lo_q[23:16];
   assign ob[3] = opc_lo_q[31:24];
   assign ob[4] = opc_hi_q[7:0];
   assign ob[5] = opc_hi_q[15:8];
   assign start_req = wr_take & (avs_address == REG_CTRL) &
                      avs_byteenable[0] & avs_writedata[CTRL_START];

   always_comb
   begin
      has_pfx = (ob[0] == OP_PFX_IX) | (ob[0] == OP_PFX_IY);
      pfx = ob[0];
      fin = has_pfx ? ob[2] : ob[1];
      lo = has_pfx ? ob[3] : ob[2];
      hi = has_pfx ? ob[4] : ob[3];
      // operands always low byte first
      disp = {hi, lo};
      dec_block = 1'b0;
      dec_word = 1'b0;
      dec_single = 1'b0;
      dec_mem = 1'b0;
      dec_bad = 1'b0;
      src_reg = RST_BYTE;
      ea = RST_WORD;
      if (!has_pfx && ob[0] == OP_PFX_ED && ob[1] == OP_BLK_BYTE)
      begin
         dec_block = 1'b1;
      end
      else if (!has_pfx && ob[0] == OP_PFX_ED && ob[1] == OP_BLK_WORD)
      begin
         dec_block = 1'b1;
         dec_word = 1'b1;
      end
      else if ((has_pfx ? ob[1] : ob[0]) != OP_PFX_ED ||
               fin[2:0] != OP_OUT_TAIL)
      begin
         dec_bad = 1'b1;
      end
      else if (!has_pfx)
      begin
         // RULE11 register form
         dec_single = fin[7:6] == OP_REG_HEAD;
         dec_bad = fin[7:6] != OP_REG_HEAD;
         case (fin[5:3])
            3'b000: src_reg = bc_q[15:8];
            3'b001: src_reg = bc_q[7:0];
            3'b010: src_reg = de_q[15:8];
            3'b011: src_reg = de_q[7:0];
            3'b100: src_reg = hl_q[15:8];
            3'b101: src_reg = hl_q[7:0];
            3'b111: src_reg = acc_q;
            default: src_reg = RST_BYTE;
         endcase
      end
      else if (pfx == OP_PFX_IX)
      begin
         dec_single = 1'b1;
         dec_mem = 1'b1;
         // RULE12 direct address
         if (fin == OP_DIRECT)
         begin
            ea = disp;
         end
         // RULE15 stack relative
         else if (fin == OP_STACK)
         begin
            ea = sp_q + disp;
         end
         // RULE16 base index pairs
         else if (fin[7:6] == OP_REG_HEAD && fin[5:3] == BX_HL_IX)
         begin
            ea = hl_q + ix_q;
         end
         else if (fin[7:6] == OP_REG_HEAD && fin[5:3] == BX_HL_IY)
         begin
            ea = hl_q + iy_q;
         end
         else if (fin[7:6] == OP_REG_HEAD && fin[5:3] == BX_IX_IY)
         begin
            ea = ix_q + iy_q;
         end
         // RULE11 index half registers
         else if (fin[7:6] == OP_REG_HEAD && fin[5:4] == 2'b10)
         begin
            dec_mem = 1'b0;
            src_reg = fin[3] ? ix_q[7:0] : ix_q[15:8];
         end
         else
         begin
            dec_single = 1'b0;
            dec_mem = 1'b0;
            dec_bad = 1'b1;
         end
      end
      else
      begin
         dec_single = 1'b1;
         dec_mem = 1'b1;
         // RULE13 indexed with displacement
         if (fin == OP_X_IX)
         begin
            ea = ix_q + disp;
         end
         else if (fin == OP_X_IY)
         begin
            ea = iy_q + disp;
         end
         // RULE14 relative to next instruction
         else if (fin == OP_REL)
         begin
            ea = pc_q + REL_INSN_LEN + disp;
         end
         else if (fin[7:6] == OP_REG_HEAD && fin[5:4] == 2'b10)
         begin
            dec_mem = 1'b0;
            src_reg = fin[3] ? iy_q[7:0] : iy_q[15:8];
         end
         else
         begin
            dec_single = 1'b0;
            dec_mem = 1'b0;
            dec_bad = 1'b1;
         end
      end
   end

   // ************************************************************
   // execution sequencer and cpu registers
   // ************************************************************
   assign int_accept = accept_q;
   assign priv_trap = trap_pulse_q;
   assign io_out = io_q;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state_q <= ST_IDLE;
         bc_q <= RST_WORD;
         hl_q <= RST_WORD;
         ix_q <= RST_WORD;
         iy_q <= RST_WORD;
         sp_q <= RST_WORD;
         pc_q <= RST_WORD;
         de_q <= RST_WORD;
         saved_pc_q <= RST_WORD;
         acc_q <= RST_BYTE;
         page_q <= RST_BYTE;
         flags_q <= RST_BYTE;
         opc_lo_q <= RST_RDATA;
         opc_hi_q <= RST_WORD;
         user_q <= 1'b0;
         inhibit_q <= 1'b0;
         done_q <= 1'b0;
         trap_q <= 1'b0;
         intr_q <= 1'b0;
         illegal_q <= 1'b0;
         is_block_q <= 1'b0;
         word_q <= 1'b0;
         data_q <= RST_WORD;
         trap_pulse_q <= 1'b0;
         accept_q <= 1'b0;
         io_q <= '0;
      end
      else
      begin
         io_q.wr <= 1'b0;
         trap_pulse_q <= 1'b0;
         accept_q <= 1'b0;
         // software loads registers only while idle
         if (wr_take && state_q == ST_IDLE && !avs_address[MEM_SEL_BIT])
         begin
            case (avs_address)
               REG_CTRL:
               begin
                  if (avs_byteenable[0])
                  begin
                     user_q <= avs_writedata[CTRL_USER];
                     inhibit_q <= avs_writedata[CTRL_INHIBIT];
                  end
               end
               REG_OPC_LO: opc_lo_q <= avs_writedata;
               REG_OPC_HI: opc_hi_q <= avs_writedata[15:0];
               REG_BC: bc_q <= merge16(bc_q, avs_writedata, avs_byteenable);
               REG_HL: hl_q <= merge16(hl_q, avs_writedata, avs_byteenable);
               REG_IX: ix_q <= merge16(ix_q, avs_writedata, avs_byteenable);
               REG_IY: iy_q <= merge16(iy_q, avs_writedata, avs_byteenable);
               REG_SP: sp_q <= merge16(sp_q, avs_writedata, avs_byteenable);
               REG_PC: pc_q <= merge16(pc_q, avs_writedata, avs_byteenable);
               REG_DE: de_q <= merge16(de_q, avs_writedata, avs_byteenable);
               REG_IOPAGE: page_q <= avs_writedata[7:0];
               REG_FLAGS: flags_q <= avs_writedata[7:0];
               REG_ACC: acc_q <= avs_writedata[7:0];
               default: ;
            endcase
         end
         case (state_q)
            ST_IDLE:
            begin
               if (start_req)
               begin
                  state_q <= ST_DECODE;
                  done_q <= 1'b0;
                  trap_q <= 1'b0;
                  intr_q <= 1'b0;
                  illegal_q <= 1'b0;
               end
            end
            ST_DECODE:
            begin
               is_block_q <= dec_block;
               word_q <= dec_word;
               if (dec_bad | ~(dec_block | dec_single))
               begin
                  illegal_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
               // RULE7 privileged trap
               else if (user_q & inhibit_q)
               begin
                  trap_q <= 1'b1;
                  trap_pulse_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
               else if (dec_block)
               begin
                  state_q <= ST_FETCH;
               end
               else
               begin
                  // RULE8 one source byte
                  data_q <= {RST_BYTE, dec_mem ? mem[ea[7:0]] : src_reg};
                  state_q <= ST_OUTPUT;
               end
            end
            ST_FETCH:
            begin
               // RULE1 fetch at pointer
               // RULE17 low byte low half
               data_q <= word_q ? {mem[8'(hl_q + 16'h0001)], mem[hl_q[7:0]]}
                                : {RST_BYTE, mem[hl_q[7:0]]};
               state_q <= ST_OUTPUT;
            end
            ST_OUTPUT:
            begin
               // RULE9 page, count, port on address
               // RULE18 full address for peripheral
               io_q.addr <= {page_q, bc_q};
               io_q.data <= data_q;
               io_q.word <= word_q & is_block_q;
               io_q.wr <= 1'b1;
               if (is_block_q)
               begin
                  // RULE1 count down and advance
                  // RULE3 zero wraps so 256 steps
                  bc_q[15:8] <= bc_q[15:8] - 8'h01;
                  hl_q <= hl_q + (word_q ? 16'h0002 : 16'h0001);
                  state_q <= ST_CHECK;
               end
               else
               begin
                  // RULE10 flags untouched
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_CHECK:
            begin
               // RULE2 end on zero count
               if (bc_q[15:8] == 8'h00)
               begin
                  // RULE6 set Z and N only
                  flags_q[FLAG_Z] <= 1'b1;
                  flags_q[FLAG_N] <= 1'b1;
                  done_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
               // RULE4 interrupt between steps
               else if (int_pending)
               begin
                  // RULE5 resume from instruction start
                  saved_pc_q <= pc_q;
                  intr_q <= 1'b1;
                  accept_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
               else
               begin
                  state_q <= ST_FETCH;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

/* ioxe_exec_assertions.sv */
// concurrent checks on the ports of the I/O output executor
// ****************************************************************
// checker
// ****************************************************************
module ioxe_exec_chk
   import ioxe_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic int_pending,
   input wire logic int_accept,
   input wire logic priv_trap,
   input wire ioxe_pkg::ioxe_io_type io_out
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic wr;
   assign wr = io_out.wr;
   // two writes one step apart
   sequence s_step;
      wr ##3 wr;
   endsequence
   sequence s_quiet;
      !wr ##1 !wr;
   endsequence
   AST_WR_PULSE: assert property (wr |=> s_quiet)
      else $error("io write pulse not followed by a quiet gap");
   AST_COUNT_DOWN: assert property (s_step |->
      io_out.addr[15:8] == 8'($past(io_out.addr[15:8], 3) - 8'h01))
      else $error("count byte did not drop by one per step");
   AST_PORT_PAGE: assert property (s_step |->
      io_out.addr[23:16] == $past(io_out.addr[23:16], 3)
      && io_out.addr[7:0] == $past(io_out.addr[7:0], 3))
      else $error("port or page byte moved within a block");
   AST_REPEAT: assert property ((wr && io_out.word
      && io_out.addr[15:8] != 8'h01 && !int_pending) ##1 !int_pending
      |-> ##2 wr)
      else $error("block stopped with count left");
   AST_LAST: assert property (wr && io_out.addr[15:8] == 8'h01
      |-> ##1 (!wr) [*6])
      else $error("write after final step");
   AST_TRAP_QUIET: assert property (priv_trap |=>
      (!priv_trap && !wr) [*4])
      else $error("write or long pulse after trap");
   AST_INT_CAUSE: assert property (int_accept |-> $past(int_pending))
      else $error("interrupt stop without request");
   AST_INT_QUIET: assert property (int_accept |=>
      (!int_accept && !wr) [*3])
      else $error("activity after interrupt stop");
   AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_WAIT_ANSWER: assert property ((avs_read || avs_write)
      && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered");
endmodule
bind ioxe_exec ioxe_exec_chk u_chk
(
   .core_clk(core_clk),
   .reset(reset),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest),
   .int_pending(int_pending),
   .int_accept(int_accept),
   .priv_trap(priv_trap),
   .io_out(io_out)
);

/* ioxe_periph.sv */
// peripheral model that logs every output write cycle
// ****************************************************************
// peripheral
// ****************************************************************
module ioxe_periph
   import ioxe_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset,
   input wire ioxe_pkg::ioxe_io_type io_out
);
   timeunit 1ns;
   timeprecision 1ps;
   ioxe_io_type log[$];
   always @(posedge core_clk)
   begin
      if (!reset && io_out.wr === 1'b1)
         log.push_back(io_out);
   end
endmodule

/* io_output_instruction_exec_tb_top.sv */
// self-checking testbench for the I/O output executor
module io_output_instruction_exec_tb_top import ioxe_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************************************
   // stimulus and checks
   // ****************************************************************
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [10:0] avs_address = 11'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic int_pending = 1'b0;
   logic int_accept;
   logic priv_trap;
   ioxe_io_type io_out;
   logic [31:0] rd;
   int failures = 0;
   int n_tests = 0;
   int n_int = 0;
   int n_trap = 0;
   initial forever #5 core_clk = ~core_clk;
   ioxe_exec dut (.core_clk(core_clk), .reset(reset),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .int_pending(int_pending),
      .int_accept(int_accept), .priv_trap(priv_trap), .io_out(io_out));
   ioxe_periph peer (.core_clk(core_clk), .reset(reset), .io_out(io_out));
   always @(posedge core_clk)
   begin
      if (int_accept === 1'b1)
         n_int++;
      if (priv_trap === 1'b1)
         n_trap++;
   end
   function automatic logic [7:0] mpat(input logic [7:0] i);
      return i ^ 8'h5A;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic timeout();
      failures++;
      final_report();
   endtask
   // request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [10:0] a,
      input logic [31:0] d);
      int i;
      @(posedge core_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= ~w;
      avs_writedata <= d;
      for (i = 0; i < 20; i++)
      begin
         @(posedge core_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (i == 20)
         timeout();
   endtask
   task automatic rchk(input logic [10:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   // load opcode, start, poll busy under a bound
   task automatic run(input logic [47:0] op, input logic [2:0] ctl);
      int i;
      peer.log.delete();
      bus(1'b1, REG_OPC_LO, op[31:0]);
      bus(1'b1, REG_OPC_HI, {16'h0000, op[47:32]});
      bus(1'b1, REG_CTRL, {29'h0, ctl});
      for (i = 0; i < 1000; i++)
      begin
         bus(1'b0, REG_STATUS, 32'h0);
         if (rd[0] === 1'b0)
            break;
      end
      if (i == 1000)
         timeout();
   endtask
   task automatic test_reset();
      check({31'h0, avs_waitrequest}, 32'h1);
      rchk(REG_BC, 32'h0);
      bus(1'b1, REG_STATUS, 32'hFF);
      rchk(REG_STATUS, 32'h0);
      rchk(11'h03C, 32'h0);
      $display("test reset done");
   endtask
   task automatic test_single();
      int i;
      ioxe_io_type e;
      logic [47:0] ops [12] = '{48'h79ED, 48'h59ED, 48'h61EDDD, 48'h69EDFD,
         48'h013379EDDD, 48'h010539EDFD, 48'h010429EDFD, 48'h011041EDFD,
         48'h010201EDDD, 48'h49EDDD, 48'h51EDDD, 48'h59EDDD};
      logic [7:0] exb [12] = '{8'h9C, 8'h12, 8'h11, 8'h30, 8'h69, 8'h7F,
         8'h6E, 8'h3F, 8'h18, 8'h6A, 8'h1A, 8'h0A};
      bus(1'b1, REG_BC, 32'h1650);
      bus(1'b1, REG_HL, 32'h0010);
      bus(1'b1, REG_IX, 32'h1120);
      bus(1'b1, REG_IY, 32'h2230);
      bus(1'b1, REG_SP, 32'h0040);
      bus(1'b1, REG_PC, 32'h0050);
      bus(1'b1, REG_DE, 32'h3412);
      bus(1'b1, REG_ACC, 32'h9C);
      bus(1'b1, REG_IOPAGE, 32'h32);
      bus(1'b1, REG_FLAGS, 32'hA5);
      for (i = 0; i < 12; i++)
      begin
         run(ops[i], 3'h1);
         e = peer.log[0];
         check(32'(peer.log.size()), 32'h1);
         check({8'h0, e.addr}, 32'h321650);
         // modes
         check({23'h0, e.word, e.data[7:0]}, {24'h0, exb[i]});
         rchk(REG_FLAGS, 32'hA5);
      end
      $display("test single done");
   endtask
   task automatic test_trap();
      int i;
      int t0;
      logic [2:0] cs [3] = '{3'h7, 3'h3, 3'h5};
      logic [31:0] ew [3] = '{32'h0, 32'h1, 32'h1};
      for (i = 0; i < 3; i++)
      begin
         t0 = n_trap;
         run(48'h79ED, cs[i]);
         check(32'(peer.log.size()), ew[i]);
         check(32'(n_trap - t0), 32'h1 - ew[i]);
         check({31'h0, rd[2]}, 32'h1 - ew[i]);
      end
      run(48'h78ED, 3'h1);
      check(rd, 32'h10);
      check(32'(peer.log.size()), 32'h0);
      run(48'h71ED, 3'h1);
      check({24'h0, peer.log[0].data[7:0]}, 32'h0);
      $display("test trap done");
   endtask
   task automatic test_word();
      bus(1'b1, 11'h410, 32'h90);
      bus(1'b1, 11'h414, 32'h3A);
      bus(1'b1, 11'h418, 32'h67);
      bus(1'b1, 11'h41C, 32'hB8);
      bus(1'b1, REG_BC, 32'h0244);
      bus(1'b1, REG_HL, 32'h0004);
      bus(1'b1, REG_IOPAGE, 32'h31);
      bus(1'b1, REG_FLAGS, 32'h81);
      run(48'h93ED, 3'h1);
      check(rd, 32'h22);
      check(32'(peer.log.size()), 32'h2);
      check({7'h0, peer.log[0].word, peer.log[0].addr}, 32'h1310244);
      check({16'h0, peer.log[0].data}, 32'h3A90);
      check({8'h0, peer.log[1].addr}, 32'h310144);
      check({16'h0, peer.log[1].data}, 32'hB867);
      rchk(REG_BC, 32'h0044);
      rchk(REG_HL, 32'h0008);
      rchk(REG_FLAGS, 32'hC3);
      $display("test word done");
   endtask
   task automatic test_int();
      int t0;
      t0 = n_int;
      bus(1'b1, REG_BC, 32'h0344);
      bus(1'b1, REG_HL, 32'h0010);
      bus(1'b1, REG_PC, 32'h1234);
      bus(1'b1, REG_FLAGS, 32'h81);
      int_pending <= 1'b1;
      run(48'hB3ED, 3'h1);
      check(32'(peer.log.size()), 32'h1);
      check(32'(n_int - t0), 32'h1);
      check({31'h0, rd[3]}, 32'h1);
      rchk(REG_SAVED_PC, 32'h1234);
      rchk(REG_BC, 32'h0244);
      rchk(REG_HL, 32'h0011);
      rchk(REG_FLAGS, 32'h81);
      int_pending <= 1'b0;
      run(48'hB3ED, 3'h1);
      check(32'(peer.log.size()), 32'h2);
      check({24'h0, peer.log[1].addr[15:8]}, 32'h01);
      rchk(REG_BC, 32'h0044);
      rchk(REG_FLAGS, 32'hC3);
      $display("test interrupt done");
   endtask
   task automatic test_zero();
      bus(1'b1, REG_BC, 32'h0044);
      bus(1'b1, REG_HL, 32'h0000);
      run(48'hB3ED, 3'h1);
      check(32'(peer.log.size()), 32'h100);
      check({24'h0, peer.log[0].addr[15:8]}, 32'h00);
      check({24'h0, peer.log[1].addr[15:8]}, 32'hFF);
      check({24'h0, peer.log[255].data[7:0]}, {24'h0, mpat(8'hFF)});
      rchk(REG_HL, 32'h0100);
      $display("test zero count done");
   endtask
   initial
   begin
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      test_reset();
      for (int k = 0; k < 256; k++)
         bus(1'b1, {1'b1, 8'(k), 2'b00}, {24'h0, mpat(8'(k))});
      test_single();
      test_trap();
      test_word();
      test_int();
      test_zero();
      final_report();
   end
endmodule
